// *** hdl/phy_status_pkg.sv ***
// Constants, types and register layout for the PHY status/control bank.
// Assumes a 50 MHz management-side clock and a decoded register port.
package phy_status_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 20;

  // Register offsets on the management port (5-bit address)
  localparam logic [4:0] QUICK_STATUS_ADDR = 5'h11;
  localparam logic [4:0] TENBASE_OPS_ADDR = 5'h12;

  // Quick status field positions
  localparam int QS_SIG_LOST = 10;
  localparam int QS_LOCK_ERR = 9;
  localparam int QS_FALSE_CAR = 8;
  localparam int QS_INV_SYM = 7;
  localparam int QS_HALT_SYM = 6;
  localparam int QS_PREM_END = 5;
  localparam int QS_AN_DONE = 4;
  localparam int QS_SIG_DET = 3;
  localparam int QS_JABBER = 2;
  localparam int QS_REM_FAULT = 1;
  localparam int QS_LINK = 0;

  // 10Base-T operations field positions
  localparam int TO_REM_JABBER = 15;
  localparam int TO_POL_REV = 14;
  localparam int TO_RSVD_HI_MSB = 13;
  localparam int TO_RSVD_HI_LSB = 6;
  localparam int TO_JAB_INH = 5;
  localparam int TO_RSVD_LO = 4;
  localparam int TO_APOL_INH = 3;
  localparam int TO_SQE_INH = 2;
  localparam int TO_LLOSS_INH = 1;
  localparam int TO_SQL_INH = 0;

  // Reset value of the writable part of the operations register
  localparam logic [13:0] TENBASE_OPS_RESET = 14'h0010;

  // Timing figures in their own units, then cycle counts
  localparam int unsigned JABBER_MS = 20;
  localparam int unsigned LINK_LOSS_MS = 100;
  localparam int unsigned SQE_DELAY_NS = 1000;
  localparam int unsigned SQE_WIDTH_NS = 1000;
  localparam int unsigned JABBER_CYC = JABBER_MS * (CLK_HZ / 1000);
  localparam int unsigned LINK_LOSS_CYC = LINK_LOSS_MS * (CLK_HZ / 1000);
  localparam int unsigned SQE_DELAY_CYC = (SQE_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SQE_WIDTH_CYC = SQE_WIDTH_NS / CLK_NS;
  localparam int CNT_W = 24;

  // Symbol classes delivered by the 100Base decoder each clock
  typedef enum logic [2:0] {
    SYM_IDLE = 3'b000,
    SYM_DATA = 3'b001,
    SYM_J = 3'b010,
    SYM_K = 3'b011,
    SYM_T = 3'b100,
    SYM_R = 3'b101,
    SYM_HALT = 3'b110,
    SYM_BAD = 3'b111
  } sym_e;

  // One-cycle receive stream events
  typedef struct packed {
    logic false_carrier;
    logic invalid_sym;
    logic halt_sym;
    logic prem_end;
  } rx_evt_s;

  // Control fields of the operations register
  typedef struct packed {
    logic jabber_inh;
    logic apol_inh;
    logic sqe_inh;
    logic lloss_inh;
    logic squelch_inh;
  } ten_ctrl_s;

endpackage

// *** hdl/rx_symbol_checker.sv ***
// 100Base receive symbol stream checker: start delimiter, errors, ends.
// Assumes symbols arrive on the system clock, one class per valid cycle.
`timescale 1ns/100ps
module rx_symbol_checker (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic enable_i, // 100Base mode active
  input wire logic sym_valid_i, // Symbol class valid this cycle
  input wire phy_status_pkg::sym_e sym_i, // Symbol class
  output phy_status_pkg::rx_evt_s evt_o, // One-cycle events, registered
  output logic rx_er_o // Receive error to MAC, registered
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GOT_J = 2'b01,
    ST_IN_PKT = 2'b10,
    ST_GOT_T = 2'b11
  } chk_state_e;

  chk_state_e state_reg;
  chk_state_e state_next;
  phy_status_pkg::rx_evt_s evt_next;
  logic idle_seen_reg;
  logic er_next;

  // Stream decode; events are only judged while 100Base mode is enabled
  always_comb begin
    state_next = state_reg;
    evt_next = '0;
    er_next = 1'b0;
    if (!enable_i) begin
      state_next = ST_IDLE;
    end else if (sym_valid_i) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (sym_i == phy_status_pkg::SYM_J) begin
            state_next = ST_GOT_J;
          end else if (sym_i != phy_status_pkg::SYM_IDLE) begin
            evt_next.false_carrier = 1'b1;
          end
        end
        ST_GOT_J: begin
          if (sym_i == phy_status_pkg::SYM_K) begin
            state_next = ST_IN_PKT;
          end else begin
            evt_next.false_carrier = 1'b1;
            state_next = ST_IDLE;
          end
        end
        ST_IN_PKT: begin
          if (sym_i == phy_status_pkg::SYM_BAD) begin
            evt_next.invalid_sym = 1'b1;
            er_next = 1'b1;
          end else if (sym_i == phy_status_pkg::SYM_HALT) begin
            evt_next.halt_sym = 1'b1;
            er_next = 1'b1;
          end else if (sym_i == phy_status_pkg::SYM_IDLE && idle_seen_reg)
          begin
            evt_next.prem_end = 1'b1;
            er_next = 1'b1;
            state_next = ST_IDLE;
          end else if (sym_i == phy_status_pkg::SYM_T) begin
            state_next = ST_GOT_T;
          end
        end
        ST_GOT_T: begin
          // Whatever follows T the packet is over
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Remembers a lone idle inside a packet
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_seen_reg <= 1'b0;
    end else if (sym_valid_i) begin
      idle_seen_reg <= (state_reg == ST_IN_PKT)
                       && (sym_i == phy_status_pkg::SYM_IDLE);
    end
  end

  // State and registered outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      evt_o <= '0;
      rx_er_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      evt_o <= evt_next;
      rx_er_o <= er_next;
    end
  end

endmodule

// *** hdl/phy_rx_status_and_tenbase_ctrl.sv ***
// PHY quick status and 10Base-T operations registers with the 10Base-T
// link, jabber, polarity and SQE controls they steer.
// Assumes a decoded management register port from the serial front end.
//
// Contract
// - Signal-lost flag sets on loss of 100Base receive signal, stays.
// - Lock-error flag latches when receive PLL fails to lock.
// - False-carrier flag latches when start is not a valid J/K pair.
// - Invalid symbol in a packet raises receive error and its flag.
// - Halt symbol in a packet is signalled and its flag latched.
// - Two idles inside a packet set premature-end and are signalled.
// - The six receive fault flags latch high, clear on read or reset.
// - Receive fault flags mean nothing in 10Base-T mode.
// - Negotiation-complete reads zero while running or disabled.
// - Negotiation-complete sets only after negotiation has finished.
// - Live signal-detect shows signal presence in 100Base-TX mode.
// - Jabber bit behaves as the basic status jabber bit.
// - Remote-fault bit behaves as the basic status remote-fault bit.
// - Link bit behaves as basic link status, latching low.
// - Auto polarity correction runs unless its inhibit bit is one.
// - SQE test pulse is produced unless its inhibit bit is one.
// - Link-loss inhibit forces the link integrity machine to pass.
// - Remote-jabber flag latches on receive jabber, clears on read.
// - Polarity-reversed status follows detected receive pair polarity.
// - Jabber inhibit skips the transmit jabber check.
// - Without squelch inhibit, link needs valid data then idle.
`timescale 1ns/100ps
module phy_rx_status_and_tenbase_ctrl #(
  parameter int unsigned JABBER_LIMIT = phy_status_pkg::JABBER_CYC,
  parameter int unsigned LINK_LOSS_LIMIT = phy_status_pkg::LINK_LOSS_CYC
) (
  input wire logic clk_sys_i, // 50 MHz system clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic [4:0] reg_addr_i, // Register address
  input wire logic reg_rd_i, // Read strobe, one cycle
  input wire logic reg_wr_i, // Write strobe, one cycle
  input wire logic [15:0] reg_wdata_i, // Write data
  output logic [15:0] reg_rdata_o, // Read data, registered
  output logic reg_rvalid_o, // Read data valid pulse
  input wire logic speed_100_i, // 100Base mode selected
  input wire logic an_enable_i, // Negotiation enable control bit
  input wire logic sym_valid_i, // 100Base symbol valid
  input wire phy_status_pkg::sym_e sym_i, // 100Base symbol class
  input wire logic sig_det_pin_i, // Receive signal present, async
  input wire logic pll_lock_pin_i, // Receive PLL locked, async
  input wire logic pol_rev_pin_i, // Receive pair reversed, async
  input wire logic rem_fault_pin_i, // Remote fault seen, async
  input wire logic an_done_pin_i, // Negotiation finished, async
  input wire logic tx_en_pin_i, // MAC transmit enable, async
  input wire logic rx_data10_i, // 10Base valid data seen
  input wire logic rx_idle10_i, // 10Base idle seen
  output logic rx_er_o, // Receive error to MAC
  output logic link_pass_o, // 10Base link integrity pass
  output logic jabber_o, // Transmit jabber active
  output logic pol_correct_o, // Apply polarity correction
  output logic sqe_col_o // SQE test collision pulse
);

  localparam int NSYNC = 6;

  typedef enum logic [1:0] {
    LK_FAIL = 2'b00,
    LK_DATA = 2'b01,
    LK_PASS = 2'b10
  } link_state_e;

  typedef enum logic [1:0] {
    SQ_OFF = 2'b00,
    SQ_WAIT = 2'b01,
    SQ_PULSE = 2'b10
  } sqe_state_e;

  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_n;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;
  logic [NSYNC-1:0] pin_reg;
  logic sig_det;
  logic pll_lock;
  logic pol_rev;
  logic rem_fault;
  logic an_done;
  logic tx_en;
  logic sig_det_d_reg;
  logic tx_en_d_reg;
  phy_status_pkg::rx_evt_s rx_evt;
  phy_status_pkg::ten_ctrl_s ctrl;
  logic [13:0] ops_reg;
  logic [5:0] rx_flag_reg;
  logic [5:0] rx_set;
  logic jab_flag_reg;
  logic rflt_flag_reg;
  logic link_lat_reg;
  logic rjab_flag_reg;
  logic rd_qs;
  logic rd_ops;
  logic [15:0] qs_view;
  logic [15:0] ops_view;
  link_state_e link_reg;
  sqe_state_e sqe_reg;
  logic [phy_status_pkg::CNT_W-1:0] loss_cnt_reg;
  logic [phy_status_pkg::CNT_W-1:0] jab_cnt_reg;
  logic [phy_status_pkg::CNT_W-1:0] rjab_cnt_reg;
  logic [phy_status_pkg::CNT_W-1:0] sqe_cnt_reg;
  logic rjab_hit;

  // Saturating counter step shared by every timer here
  function automatic logic [phy_status_pkg::CNT_W-1:0] cnt_step(
    input logic [phy_status_pkg::CNT_W-1:0] cnt
  );
    cnt_step = (&cnt) ? cnt : cnt + 1'b1;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // Async pins: three flops, a change counts once stages two and three agree
  assign pin_raw = {tx_en_pin_i, an_done_pin_i, rem_fault_pin_i,
                    pol_rev_pin_i, pll_lock_pin_i, sig_det_pin_i};
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));
    end
  end
  assign {tx_en, an_done, rem_fault, pol_rev, pll_lock, sig_det} = pin_reg;

  // Edge history for signal loss and end of transmit
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sig_det_d_reg <= 1'b0;
      tx_en_d_reg <= 1'b0;
    end else begin
      sig_det_d_reg <= sig_det;
      tx_en_d_reg <= tx_en;
    end
  end

  rx_symbol_checker u_checker (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .enable_i(speed_100_i),
    .sym_valid_i(sym_valid_i),
    .sym_i(sym_i),
    .evt_o(rx_evt),
    .rx_er_o(rx_er_o)
  );

  // Management decode; a read clears the latches of the register it reads
  assign rd_qs = reg_rd_i && (reg_addr_i == phy_status_pkg::QUICK_STATUS_ADDR);
  assign rd_ops = reg_rd_i && (reg_addr_i == phy_status_pkg::TENBASE_OPS_ADDR);

  // Fault events only count in 100Base mode; in 10Base-T they stay quiet
  assign rx_set = {6{speed_100_i}} & {
    sig_det_d_reg & ~sig_det,
    sig_det & ~pll_lock,
    rx_evt.false_carrier,
    rx_evt.invalid_sym,
    rx_evt.halt_sym,
    rx_evt.prem_end};

  // Latching-high receive fault flags; set beats the clearing read
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_flag_reg <= '0;
    end else begin
      rx_flag_reg <= rx_set | (rd_qs ? 6'h00 : rx_flag_reg);
    end
  end

  // Mirrors of basic status: jabber, remote fault latch high, link low
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      jab_flag_reg <= 1'b0;
      rflt_flag_reg <= 1'b0;
      link_lat_reg <= 1'b0;
    end else begin
      jab_flag_reg <= jabber_o | (jab_flag_reg & ~rd_qs);
      rflt_flag_reg <= rem_fault | (rflt_flag_reg & ~rd_qs);
      // A read reloads the live link; a drop in the read cycle still wins
      link_lat_reg <= rd_qs ? link_pass_o
                    : (link_lat_reg & link_pass_o);
    end
  end

  // Operations control bits, reserved bits kept as written
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ops_reg <= phy_status_pkg::TENBASE_OPS_RESET;
    end else if (reg_wr_i
                 && reg_addr_i == phy_status_pkg::TENBASE_OPS_ADDR) begin
      // Reserved defaults are the writer's duty and are not forced here
      ops_reg <= reg_wdata_i[13:0];
    end
  end
  assign ctrl.jabber_inh = ops_reg[phy_status_pkg::TO_JAB_INH];
  assign ctrl.apol_inh = ops_reg[phy_status_pkg::TO_APOL_INH];
  assign ctrl.sqe_inh = ops_reg[phy_status_pkg::TO_SQE_INH];
  assign ctrl.lloss_inh = ops_reg[phy_status_pkg::TO_LLOSS_INH];
  assign ctrl.squelch_inh = ops_reg[phy_status_pkg::TO_SQL_INH];

  // Read views
  always_comb begin
    qs_view = 16'h0000;
    qs_view[phy_status_pkg::QS_SIG_LOST:phy_status_pkg::QS_PREM_END] =
      rx_flag_reg;
    qs_view[phy_status_pkg::QS_AN_DONE] =
      an_enable_i & an_done;
    qs_view[phy_status_pkg::QS_SIG_DET] = sig_det;
    qs_view[phy_status_pkg::QS_JABBER] = jab_flag_reg;
    qs_view[phy_status_pkg::QS_REM_FAULT] = rflt_flag_reg;
    qs_view[phy_status_pkg::QS_LINK] = link_lat_reg;
    ops_view = {2'b00, ops_reg};
    ops_view[phy_status_pkg::TO_REM_JABBER] = rjab_flag_reg;
    ops_view[phy_status_pkg::TO_POL_REV] = pol_rev;
  end

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (rd_qs) begin
        reg_rdata_o <= qs_view;
      end else if (rd_ops) begin
        reg_rdata_o <= ops_view;
      end else if (reg_rd_i) begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // Receive jabber: valid data lasting beyond the jabber limit
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rjab_cnt_reg <= '0;
    end else begin
      rjab_cnt_reg <= rx_data10_i ? cnt_step(rjab_cnt_reg) : '0;
    end
  end
  assign rjab_hit = !speed_100_i
                    && rjab_cnt_reg == JABBER_LIMIT[phy_status_pkg::CNT_W-1:0];

  // Remote jabber flag is information only and clears on read
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rjab_flag_reg <= 1'b0;
    end else begin
      rjab_flag_reg <= rjab_hit | (rjab_flag_reg & ~rd_ops);
    end
  end

  // Transmit jabber check, skipped entirely while inhibited
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      jab_cnt_reg <= '0;
      jabber_o <= 1'b0;
    end else if (ctrl.jabber_inh || !tx_en) begin
      jab_cnt_reg <= '0;
      jabber_o <= 1'b0;
    end else begin
      jab_cnt_reg <= cnt_step(jab_cnt_reg);
      if (jab_cnt_reg >= JABBER_LIMIT[phy_status_pkg::CNT_W-1:0]) begin
        jabber_o <= 1'b1;
      end
    end
  end

  // Polarity correction only while not inhibited
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pol_correct_o <= 1'b0;
    end else begin
      pol_correct_o <= pol_rev & ~ctrl.apol_inh;
    end
  end

  // 10Base-T link integrity; the inhibit holds the machine in pass
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= LK_FAIL;
      loss_cnt_reg <= '0;
    end else if (ctrl.lloss_inh) begin
      link_reg <= LK_PASS;
      loss_cnt_reg <= '0;
    end else begin
      unique case (link_reg)
        LK_FAIL: begin
          loss_cnt_reg <= '0;
          if (rx_data10_i) begin
            link_reg <= ctrl.squelch_inh ? LK_PASS : LK_DATA;
          end
        end
        LK_DATA: begin
          if (rx_idle10_i) begin
            link_reg <= LK_PASS;
          end
        end
        LK_PASS: begin
          if (rx_data10_i || rx_idle10_i) begin
            loss_cnt_reg <= '0;
          end else if (loss_cnt_reg
                       >= LINK_LOSS_LIMIT[phy_status_pkg::CNT_W-1:0]) begin
            link_reg <= LK_FAIL;
          end else begin
            loss_cnt_reg <= cnt_step(loss_cnt_reg);
          end
        end
        default: begin
          link_reg <= LK_FAIL;
        end
      endcase
    end
  end

  // Link output registered from the state
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      link_pass_o <= 1'b0;
    end else begin
      link_pass_o <= (link_reg == LK_PASS) || ctrl.lloss_inh;
    end
  end

  // SQE test: a collision pulse a short delay after transmit ends
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sqe_reg <= SQ_OFF;
      sqe_cnt_reg <= '0;
      sqe_col_o <= 1'b0;
    end else begin
      unique case (sqe_reg)
        SQ_OFF: begin
          sqe_col_o <= 1'b0;
          sqe_cnt_reg <= '0;
          if (tx_en_d_reg && !tx_en && !ctrl.sqe_inh) begin
            sqe_reg <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          sqe_cnt_reg <= cnt_step(sqe_cnt_reg);
          if (sqe_cnt_reg + 1'b1
              >= phy_status_pkg::SQE_DELAY_CYC[phy_status_pkg::CNT_W-1:0])
          begin
            sqe_reg <= SQ_PULSE;
            sqe_cnt_reg <= '0;
            sqe_col_o <= ~ctrl.sqe_inh;
          end
        end
        SQ_PULSE: begin
          sqe_cnt_reg <= cnt_step(sqe_cnt_reg);
          if (sqe_cnt_reg + 1'b1
              >= phy_status_pkg::SQE_WIDTH_CYC[phy_status_pkg::CNT_W-1:0])
          begin
            sqe_reg <= SQ_OFF;
            sqe_col_o <= 1'b0;
          end
        end
        default: begin
          sqe_reg <= SQ_OFF;
        end
      endcase
    end
  end

endmodule

// *** dv/phy_status_sva.sv ***
// Checker for the status bank register port and 10Base-T controls.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module phy_status_sva (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic [4:0] reg_addr_i, // Address
  input wire logic reg_rd_i, // Read strobe
  input wire logic reg_wr_i, // Write strobe
  input wire logic [15:0] reg_wdata_i, // Write data
  input wire logic [15:0] reg_rdata_o, // Read data
  input wire logic reg_rvalid_o, // Read valid
  input wire logic speed_100_i, // 100Base mode
  input wire logic an_enable_i, // Negotiation enable
  input wire logic sym_valid_i, // Symbol valid
  input wire logic rx_er_o, // Receive error
  input wire logic link_pass_o, // Link pass
  input wire logic jabber_o, // Jabber active
  input wire logic pol_correct_o, // Polarity fix
  input wire logic sqe_col_o // SQE pulse
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire ops_wr = reg_wr_i && reg_addr_i == 5'h12;
  wire qs_rd = reg_rd_i && reg_addr_i == 5'h11;

  a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without a read");
  a_unmapped_zero: assert property (reg_rd_i && !qs_rd &&
    reg_addr_i != 5'h12 |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_qs_upper: assert property (qs_rd |=> reg_rdata_o[15:11] == 5'h00)
    else $error("quick status upper bits set");
  a_an_disabled: assert property (qs_rd && !an_enable_i |=>
    !reg_rdata_o[4]) else $error("negotiation done while disabled");
  a_rxer_cause: assert property (rx_er_o |->
    $past(sym_valid_i && speed_100_i)) else $error("stray receive error");
  a_pol_inhibit: assert property (ops_wr && reg_wdata_i[3] |->
    ##2 !pol_correct_o) else $error("polarity fixed while inhibited");
  a_lloss_pass: assert property (ops_wr && reg_wdata_i[1] |->
    ##[2:4] link_pass_o) else $error("link not forced to pass");
  a_jab_inhibit: assert property (ops_wr && reg_wdata_i[5] |->
    ##[2:3] !jabber_o) else $error("jabber shown while inhibited");
  a_sqe_width: assert property ($rose(sqe_col_o) |->
    sqe_col_o[*8]) else $error("SQE pulse too short");
endmodule

bind phy_rx_status_and_tenbase_ctrl phy_status_sva i_sva (.clk_sys_i,
  .rst_n_i, .reg_addr_i, .reg_rd_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
  .reg_rvalid_o, .speed_100_i, .an_enable_i, .sym_valid_i, .rx_er_o,
  .link_pass_o, .jabber_o, .pol_correct_o, .sqe_col_o);

// *** dv/sta_model.sv ***
// Station management model: issues register reads and writes.
// Assumes the bank takes strobes on the rising edge, answers a cycle on.
`timescale 1ns/100ps
module sta_model (
  input wire logic clk_sys_i, // Clock
  input wire logic [15:0] reg_rdata_i, // Read data
  input wire logic reg_rvalid_i, // Read valid
  output logic [4:0] reg_addr_o, // Address
  output logic reg_rd_o, // Read strobe
  output logic reg_wr_o, // Write strobe
  output logic [15:0] reg_wdata_o // Write data
);
  // Idle bus at time zero
  initial begin
    reg_addr_o = 5'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end
  // Reserved fields always go out at their defaults, whatever is asked
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= (d & 16'h002f) | 16'h0010;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
  endtask
  // Bounded wait for the answer; unknown data stands for no answer
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    d = 16'hxxxx;
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      @(posedge clk_sys_i);
      if (reg_rvalid_i === 1'b1) begin
        d = reg_rdata_i;
        break;
      end
    end
  endtask
endmodule

// *** dv/phy_rx_status_and_tenbase_ctrl_tb.sv ***
// Self-checking bench for the PHY status and 10Base-T operations bank.
// Assumes the bank, its package, the checker and the station model.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module phy_rx_status_and_tenbase_ctrl_tb;
  logic clk = 1'b0, rst_n, spd, an_en, sv, sd, pll, pol, tx, ad, rf, dt, il;
  logic [4:0] addr;
  logic rd, wr, rv, rx_er, lnk, jab, pcor, sqe;
  logic [15:0] wd, rdat, d;
  phy_status_pkg::sym_e sym;
  int failures = 0, tests_run = 0;
  int seq[$] = '{0,7,0,2,3,1,7,1,4,0,2,3,1,6,4,0,2,3,1,0,0};

  phy_rx_status_and_tenbase_ctrl #(.JABBER_LIMIT(20),
    .LINK_LOSS_LIMIT(30)) i_dut (.clk_sys_i(clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .reg_rvalid_o(rv), .speed_100_i(spd),
    .an_enable_i(an_en), .sym_valid_i(sv), .sym_i(sym),
    .sig_det_pin_i(sd), .pll_lock_pin_i(pll), .pol_rev_pin_i(pol),
    .rem_fault_pin_i(rf), .an_done_pin_i(ad), .tx_en_pin_i(tx),
    .rx_data10_i(dt), .rx_idle10_i(il), .rx_er_o(rx_er),
    .link_pass_o(lnk), .jabber_o(jab), .pol_correct_o(pcor),
    .sqe_col_o(sqe));
  sta_model i_sta (.clk_sys_i(clk), .reg_rdata_i(rdat), .reg_rvalid_i(rv),
    .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wd));

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic final_report;
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic t_reset;
    i_sta.rd(5'h12, d);
    `CHK(d, 16'h0010)
    i_sta.rd(5'h11, d);
    `CHK(d & 16'h07e0, 16'h0000)
    i_sta.rd(5'h05, d);
    `CHK(d, 16'h0000)
  endtask

  // False carrier, invalid, halt and early end in one stream
  task automatic t_stream;
    int nerr;
    nerr = 0;
    spd <= 1'b1;
    foreach (seq[i]) begin
      @(posedge clk);
      nerr += int'(rx_er === 1'b1);
      sv <= 1'b1;
      sym <= phy_status_pkg::sym_e'(seq[i][2:0]);
    end
    @(posedge clk);
    sv <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      nerr += int'(rx_er === 1'b1);
    end
    `CHK(nerr, 3)
    i_sta.rd(5'h11, d);
    `CHK(d & 16'h01e0, 16'h01e0)
    i_sta.rd(5'h11, d);
    `CHK(d & 16'h01e0, 16'h0000)
  endtask

  task automatic t_signal;
    pll <= 1'b0;
    repeat (8) @(posedge clk);
    sd <= 1'b0;
    repeat (8) @(posedge clk);
    i_sta.rd(5'h11, d);
    `CHK(d & 16'h0608, 16'h0600)
    sd <= 1'b1;
    pll <= 1'b1;
    repeat (8) @(posedge clk);
    i_sta.rd(5'h11, d);
    `CHK(d & 16'h0608, 16'h0008)
  endtask

  // Complete bit: zero while running, one when done, zero when disabled
  task automatic t_neg;
    an_en <= 1'b1;
    repeat (8) @(posedge clk);
    i_sta.rd(5'h11, d);
    `CHK(d[4], 1'b0)
    ad <= 1'b1;
    repeat (8) @(posedge clk);
    i_sta.rd(5'h11, d);
    `CHK(d[4], 1'b1)
    an_en <= 1'b0;
    i_sta.rd(5'h11, d);
    `CHK(d[4], 1'b0)
  endtask

  task automatic t_ops;
    pol <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(pcor, 1'b1)
    i_sta.wr(5'h12, 16'hffea);
    repeat (4) @(posedge clk);
    `CHK({pcor, lnk}, 2'b01)
    i_sta.rd(5'h11, d);
    `CHK(d[0], 1'b0)
    i_sta.rd(5'h11, d);
    `CHK(d[0], 1'b1)
    i_sta.rd(5'h12, d);
    `CHK(d, 16'h403a)
    i_sta.wr(5'h12, 16'h0000);
    pol <= 1'b0;
  endtask

  // SQE follows end of transmit unless inhibited
  task automatic t_sqe(input logic [15:0] ctl, input int exp);
    int n;
    n = 0;
    i_sta.wr(5'h12, ctl);
    tx <= 1'b1;
    repeat (10) @(posedge clk);
    tx <= 1'b0;
    repeat (150) begin
      @(posedge clk);
      n += int'(sqe === 1'b1);
    end
    `CHK(n, exp)
  endtask

  // Long transmit raises jabber, which mirrors into quick status
  task automatic t_jab;
    tx <= 1'b1;
    rf <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(jab, 1'b1)
    i_sta.wr(5'h12, 16'h0020);
    repeat (2) @(posedge clk);
    `CHK(jab, 1'b0)
    rf <= 1'b0;
    tx <= 1'b0;
    repeat (8) @(posedge clk);
    i_sta.rd(5'h11, d);
    `CHK(d[2], 1'b1)
    `CHK(d[1], 1'b1)
  endtask

  // Link needs data then idle; long data also flags remote jabber
  task automatic t_link;
    dt <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK(lnk, 1'b0)
    dt <= 1'b0;
    il <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(lnk, 1'b1)
    i_sta.rd(5'h12, d);
    `CHK(d[15], 1'b1)
  endtask

  // Main sequence
  initial begin
    {rst_n, spd, an_en, sv, pol, tx, ad, rf, dt, il} = 10'h000;
    {sd, pll} = 2'b11;
    sym = phy_status_pkg::SYM_IDLE;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset;
    t_stream;
    t_signal;
    t_neg;
    t_ops;
    spd <= 1'b0;
    t_sqe(16'h0000, 50);
    t_sqe(16'h0004, 0);
    t_jab;
    t_link;
    final_report;
  end

  // Watchdog well beyond the expected run
  initial begin
    #100000;
    failures++;
    final_report;
  end
endmodule
